// ==== hw/mcs_pkg.sv ====
// package of constants and types for the memory card segment and bank select
package mcs_pkg;
    // configuration strap encodings
    localparam logic MCS_POL_LOW = 1'h0;
    localparam logic MCS_POL_HIGH = 1'h1;
    // reset values of registered outputs
    localparam logic MCS_RST_SEL = 1'h0;
    localparam logic [1:0] MCS_RST_BANK = 2'h0;
    localparam logic MCS_RST_OE = 1'h0;
    localparam logic MCS_RST_WE = 1'h0;
    localparam logic [1:0] MCS_RST_STATE = 2'h0;
    // edges from a settled pin to the registered answer: two sync stages plus one
    localparam int MCS_RESP_LATENCY = 3;
    // bank index encoding, primary selected while memex low
    localparam int MCS_BANK_PRIMARY = 0;
    localparam int MCS_BANK_EXPANDED = 1;
    // one-hot segment code limits used by control software
    localparam logic [7:0] MCS_SEG_CODE_FIRST = 8'h01;
    localparam logic [7:0] MCS_SEG_CODE_LAST = 8'h80;
    // access states
    typedef enum logic [1:0]
    {
        MCS_IDLE = 2'b00,
        MCS_SERVE = 2'b01,
        MCS_IGNORE = 2'b10
    } mcs_state_t;
endpackage

// ==== hw/mcs_sync.sv ====
// two flip-flop synchroniser for pin-level inputs
`timescale 1ns/100ps
module mcs_sync
#(
    parameter int WIDTH = 1
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_r;

    // first stage is read only by the second stage
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            stage1_r <= '0;
            syncOut <= '0;
        end
        else
        begin
            stage1_r <= asyncIn;
            syncOut <= stage1_r;
        end
    end
endmodule

// ==== hw/mcs_select.sv ====
// card-level segment and bank select for a byte-wide memory card
// Functional notes
// - group enable comes on its own connector input, separate from bus signals
// - cards sharing a range: only the one with active group enable responds
// - group enable polarity is configurable, active low or active high
// - low polarity enabled while input low; high polarity while input high
// - in two-bank mode one bank answers memex low, other memex high
// - primary bank selected with memex low or in single-bank mode, expanded bank with memex high in two-bank mode
`timescale 1ns/100ps
module mcs_select
    import mcs_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic groupEnPin,
    input wire logic groupEnWired,
    input wire logic groupPolHigh,
    input wire logic twoBankMode,
    input wire logic memex,
    input wire logic memReq_n,
    input wire logic memRd_n,
    input wire logic memWr_n,
    input wire logic addrInRange,
    output logic cardSel_r,
    output logic [1:0] bankSel_r,
    output logic dataOe_r,
    output logic memWrEn_r,
    output logic [1:0] state_r
);
    logic [8:0] pinSync;
    logic grpSync;
    logic memexSync;
    logic reqAct;
    logic rdAct;
    logic wrAct;
    logic rangeSync;
    logic wiredSync;
    logic polSync;
    logic twoSync;
    logic reqSync_n;
    logic rdSync_n;
    logic wrSync_n;
    logic groupActive;
    logic cardHit;
    logic [1:0] bankNxt;
    mcs_state_t st_r;

    // all pins and straps cross into clk before any logic reads them;
    // strobes enter inverted so the cleared synchroniser reads as idle,
    // otherwise a phantom request would show for two cycles after reset
    mcs_sync #(.WIDTH(9)) uSync
    (
        .clk(clk),
        .sys_rst(sys_rst),
        .asyncIn({groupEnPin, memex, ~memReq_n, ~memRd_n, ~memWr_n, addrInRange, groupEnWired,
            groupPolHigh, twoBankMode}),
        .syncOut(pinSync)
    );
    assign {grpSync, memexSync, reqAct, rdAct, wrAct, rangeSync, wiredSync, polSync,
        twoSync} = pinSync;
    // back to active-low form for the decode below
    assign reqSync_n = ~reqAct;
    assign rdSync_n = ~rdAct;
    assign wrSync_n = ~wrAct;

    // an unwired connector leaves the card always enabled
    assign groupActive = wiredSync ? (polSync ? grpSync : ~grpSync) : 1'h1;
    // range hit counts only while this card's group line is active
    assign cardHit = groupActive && rangeSync && !reqSync_n;

    // bank choice; single-bank mode always uses the primary bank
    always_comb
    begin
        bankNxt = 2'h0;
        if (cardHit)
        begin
            if (twoSync && memexSync)
                bankNxt[MCS_BANK_EXPANDED] = 1'b1;
            else
                bankNxt[MCS_BANK_PRIMARY] = 1'b1;
        end
    end

    // access tracking, refusal recorded in st_r; the select outputs follow cardHit and do not read it
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            st_r <= MCS_IDLE;
        else
        begin
            unique case (st_r)
                MCS_IDLE:
                    if (!reqSync_n)
                        st_r <= cardHit ? MCS_SERVE : MCS_IGNORE;
                MCS_SERVE, MCS_IGNORE:
                    if (reqSync_n)
                        st_r <= MCS_IDLE;
                default:
                    st_r <= MCS_IDLE;
            endcase
        end
    end

    // card select: answers only while group, range and request agree
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            cardSel_r <= MCS_RST_SEL;
        else
            cardSel_r <= cardHit;
    end

    // bank lines follow the decode; both stay low when the card is not hit
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            bankSel_r <= MCS_RST_BANK;
        else
            bankSel_r <= bankNxt;
    end

    // data drive only on a selected read, so a foreign card never fights the bus
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            dataOe_r <= MCS_RST_OE;
        else
            dataOe_r <= cardHit && !rdSync_n;
    end

    // write strobe to memory only on a selected write
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            memWrEn_r <= MCS_RST_WE;
        else
            memWrEn_r <= cardHit && !wrSync_n;
    end

    // visible copy of the access state, one edge behind the tracker
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            state_r <= MCS_RST_STATE;
        else
            state_r <= st_r;
    end

    // checks; all run on clk and sleep during reset
    // the |=> checks hold a registered output one edge after the synced inputs that set it; the rest compare outputs in one cycle
    // group activity is worked out here from the synced pins, not from groupActive

    chk_bank_onehot: assert property (@(posedge clk) disable iff (sys_rst)
        !(bankSel_r[0] && bankSel_r[1]))
        else $error("both banks selected");

    chk_unsel_quiet: assert property (@(posedge clk) disable iff (sys_rst)
        !cardSel_r |-> (!dataOe_r && !memWrEn_r))
        else $error("unselected card drives or writes");

    chk_bank_needs_sel: assert property (@(posedge clk) disable iff (sys_rst)
        (bankSel_r != 2'h0) |-> cardSel_r)
        else $error("bank active without card select");

    chk_pol_low: assert property (@(posedge clk) disable iff (sys_rst)
        (wiredSync && !polSync && grpSync) |=> !cardSel_r)
        else $error("low polarity card selected with line high");

    chk_pol_high: assert property (@(posedge clk) disable iff (sys_rst)
        (wiredSync && polSync && !grpSync) |=> !cardSel_r)
        else $error("high polarity card selected with line low");

    chk_primary_bank: assert property (@(posedge clk) disable iff (sys_rst)
        (cardHit && !memexSync) |=> bankSel_r[MCS_BANK_PRIMARY])
        else $error("primary bank not chosen with memex low");

    chk_expanded_bank: assert property (@(posedge clk) disable iff (sys_rst)
        (cardHit && memexSync && twoSync) |=> bankSel_r[MCS_BANK_EXPANDED])
        else $error("expanded bank not chosen with memex high");

    chk_unwired_en: assert property (@(posedge clk) disable iff (sys_rst)
        (!wiredSync && rangeSync && !reqSync_n) |=> cardSel_r)
        else $error("unwired card failed to respond");

    chk_pol_low_on: assert property (@(posedge clk) disable iff (sys_rst)
        (wiredSync && !polSync && !grpSync && rangeSync && !reqSync_n) |=> cardSel_r)
        else $error("low polarity card not selected with line low");

    chk_pol_high_on: assert property (@(posedge clk) disable iff (sys_rst)
        (wiredSync && polSync && grpSync && rangeSync && !reqSync_n) |=> cardSel_r)
        else $error("high polarity card not selected with line high");

    chk_range_miss: assert property (@(posedge clk) disable iff (sys_rst)
        !rangeSync |=> !cardSel_r)
        else $error("card answered outside its range");

    chk_idle_quiet: assert property (@(posedge clk) disable iff (sys_rst)
        reqSync_n |=> (!cardSel_r && bankSel_r == 2'h0 && !dataOe_r && !memWrEn_r))
        else $error("outputs active without a request");

    chk_single_bank: assert property (@(posedge clk) disable iff (sys_rst)
        (cardHit && !twoSync) |=> (bankSel_r[MCS_BANK_PRIMARY] && !bankSel_r[MCS_BANK_EXPANDED]))
        else $error("single-bank card left the primary bank");

    chk_read_drive: assert property (@(posedge clk) disable iff (sys_rst)
        (cardHit && !rdSync_n) |=> dataOe_r)
        else $error("selected read did not drive data");

    chk_write_pass: assert property (@(posedge clk) disable iff (sys_rst)
        (cardHit && !wrSync_n) |=> memWrEn_r)
        else $error("selected write not passed to memory");

    chk_group_off: assert property (@(posedge clk) disable iff (sys_rst)
        (wiredSync && (polSync != grpSync)) |=> (!dataOe_r && !memWrEn_r))
        else $error("inactive group line let the card drive or write");

    chk_reset_quiet: assert property (@(posedge clk) disable iff (sys_rst)
        $past(sys_rst) |-> (!cardSel_r && !dataOe_r && !memWrEn_r && state_r == MCS_RST_STATE))
        else $error("outputs not at rest after reset");

    chk_state_ignore: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r == MCS_IDLE && !reqSync_n && !cardHit) |=> (st_r == MCS_IGNORE))
        else $error("foreign access not recorded as ignored");
endmodule

// ==== testbench/mcs_host_port.sv ====
// host output port model driving the card group enable lines
`timescale 1ns/100ps
module mcs_host_port
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic portWr,
    input wire logic [7:0] portData,
    output logic [7:0] portBits
);
    // all bits low after reset, so only a low-polarity or unwired card answers at first
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            portBits <= 8'h00;
        else if (portWr)
            portBits <= portData; // one bit per card, one-hot codes
    end
endmodule

// ==== testbench/tb_top.sv ====
// self-checking bench for the card segment and bank select
`timescale 1ns/100ps
module tb_top
    import mcs_pkg::*;
;
    logic clk = 1'h0;
    logic sys_rst = 1'h1;
    logic pol = MCS_POL_LOW;
    logic two = 1'h1;
    logic mx = 1'h0;
    logic req_n = 1'h1;
    logic rd_n = 1'h1;
    logic wr_n = 1'h1;
    logic rng = 1'h0;
    logic pWr = 1'h0;
    logic [7:0] pData = 8'h00;
    logic [7:0] pBits;
    logic sel;
    logic [1:0] bank;
    logic oe;
    logic we;
    logic wired = 1'h1;
    logic [1:0] st;
    int err_count = 0;
    int tests_run = 0;
    int cyc = 0;
    mcs_host_port mcs_host_port_inst (.clk(clk), .sys_rst(sys_rst), .portWr(pWr),
        .portData(pData), .portBits(pBits));
    // group enable arrives on its own pin, fed by port bit 0
    mcs_select mcs_select_inst (.clk(clk), .sys_rst(sys_rst), .groupEnPin(pBits[0]),
        .groupEnWired(wired), .groupPolHigh(pol), .twoBankMode(two), .memex(mx),
        .memReq_n(req_n), .memRd_n(rd_n), .memWr_n(wr_n), .addrInRange(rng),
        .cardSel_r(sel), .bankSel_r(bank), .dataOe_r(oe), .memWrEn_r(we), .state_r(st));
    always #50 clk = ~clk;
    // hang guard, the whole run needs just under a hundred cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            err_count++;
            results();
        end
    end
    task results;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [4:0] exp);
        tests_run++;
        if ({sel, bank, oe, we} !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %b want %b", $time, {sel, bank, oe, we}, exp);
        end
    endtask
    task chkState(input logic [1:0] exp);
        tests_run++;
        if (st !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: state %b want %b", $time, st, exp);
        end
    endtask
    // one access held past the three-edge latency, then released
    task acc(input logic w, input logic r, input logic m);
        logic s;
        @(posedge clk);
        {req_n, rd_n, wr_n, rng, mx} <= {1'h0, w, !w, r, m};
        repeat (MCS_RESP_LATENCY + 1) @(posedge clk);
        #1 s = (!wired || pBits[0] === pol) & r;
        chk({s, s & two & m, s & !(two & m), s & !w, s & w});
        chkState(s ? MCS_SERVE : MCS_IGNORE);
        @(posedge clk);
        {req_n, rd_n, wr_n} <= 3'h7;
    endtask
    task setPort(input logic [7:0] d);
        @(posedge clk);
        {pWr, pData} <= {1'h1, d};
        @(posedge clk);
        pWr <= 1'h0;
    endtask
    task t_polarity;
        for (int p = 0; p < 2; p++)
        begin
            pol <= p[0];
            setPort(MCS_SEG_CODE_FIRST);
            acc(1'h0, 1'h1, 1'h0);
            setPort(MCS_SEG_CODE_LAST);
            acc(1'h1, 1'h1, 1'h1);
        end
    endtask
    task t_banks;
        setPort(MCS_SEG_CODE_FIRST);
        for (int m = 0; m < 2; m++)
            acc(m[0], 1'h1, m[0]);
        acc(1'h1, 1'h0, 1'h1);
        two <= 1'h0;
        acc(1'h0, 1'h1, 1'h1);
    endtask
    task t_unwired;
        setPort(MCS_SEG_CODE_LAST);
        wired <= 1'h0;
        acc(1'h0, 1'h1, 1'h0);
        wired <= 1'h1;
        acc(1'h0, 1'h1, 1'h0);
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'h0;
        acc(1'h0, 1'h1, 1'h1);
        t_polarity();
        t_banks();
        t_unwired();
        results();
    end
endmodule
